// ==== hw/error_pin_and_vcm_control.sv ====
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
// Overview of operation
// - overrange enable bit 5 lets input overrange drive the error output pin.
// - internal enable bit 4 lets any internal fault drive the error output pin.
// - serial enable bit 3 lets serial read/write/CRC/clock faults drive the pin.
// - pin-control bit 2 is read-only latched error input level when enabled.
// - pin-control bit 1 makes the input pin an error input, ORed in.
// - pin-control bit 0 enables the error output pin, sources from select register.
// - buffer bit 6 powers the common-mode buffer down when set; resets zero.
// - ratio code bits 5:1 select common-mode ratio in twentieths, codes 1 and 20 to 28 reserved.
// - buffer bit 0 chooses reference ratio or fixed half analog supply.
// - serial CRC enable gates CRC checks; failure sets sticky flag; reads append CRC.
`include "error_pin_regs.svh"
module error_pin_and_vcm_control
	import error_pin_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire axi_lite_req_s axi_req,
	output axi_lite_rsp_s axi_rsp,
	input wire fault_in_s faults,
	input wire logic error_input_pin,
	output logic error_output_pin,
	output logic error_output_pin_oe,
	output logic serial_crc_append,
	output common_mode_s common_mode,
	output logic irq
);

	state_s state_reg;
	state_s state_next;

	function automatic reg_sel_e decode(input logic [`ADDR_W-1:0] addr);
		reg_sel_e sel;
		sel = SEL_NONE;
		if (addr[1:0] == 2'h0)
		begin
			case (addr[`ADDR_W-1:2])
				`IDX_SRC_SEL: sel = SEL_SRC;
				`IDX_PIN_CFG: sel = SEL_PIN;
				`IDX_BUF_CTRL: sel = SEL_BUF;
				`IDX_IRQ_STATUS: sel = SEL_STAT;
				`IDX_IRQ_CLEAR: sel = SEL_CLR;
				`IDX_IRQ_ENABLE: sel = SEL_EN;
				`IDX_CRC_CTRL: sel = SEL_CRC;
				default: sel = SEL_NONE;
			endcase
		end
		return sel;
	endfunction : decode

	// unlisted codes fall back to the mid ratio and are flagged
	function automatic logic [5:0] ratio_of(input logic [4:0] code);
		logic [5:0] r;
		r = {1'b1, `RATIO_MID};
		if (code == 5'h00 || code >= `RATIO_MID_FIRST)
			r = {1'b0, `RATIO_MID};
		else if (code >= `RATIO_HI_FIRST && code <= `RATIO_HI_LAST)
			r = {1'b0, 5'(`RATIO_HI_BASE - code)};
		else if (code > `RATIO_HI_LAST && code <= `RATIO_LO_LAST)
			r = {1'b0, 5'(`RATIO_LO_BASE - code)};
		return r;
	endfunction : ratio_of

	logic crc_fail;
	logic [`IRQ_W-1:0] events;
	logic internal_any;
	logic serial_any;
	logic err_level;

	always_comb
	begin
		crc_fail = faults.serial_crc_fail & state_reg.crc_ctrl[`CRC_EN_BIT];
		internal_any = faults.digital_overflow | faults.map_crc | faults.rate_converter
			| faults.fuse_crc | faults.data_clock_count;
		serial_any = faults.serial_read | faults.serial_write | crc_fail
			| faults.serial_clock_count;
		err_level = (state_reg.src_sel[`SRC_OVR_BIT] & faults.overrange)
			| (state_reg.src_sel[`SRC_INT_BIT] & internal_any)
			| (state_reg.src_sel[`SRC_SPI_BIT] & serial_any)
			| (state_reg.pin_cfg[`PIN_IN_EN_BIT] & error_input_pin);
		events = '0;
		events[`IRQ_OVR] = faults.overrange;
		events[`IRQ_INT] = internal_any;
		events[`IRQ_SPI] = serial_any;
		events[`IRQ_EXT] = state_reg.pin_cfg[`PIN_IN_EN_BIT] & error_input_pin;
		events[`IRQ_CRC] = crc_fail;
	end

	always_comb
	begin
		reg_sel_e wsel;
		reg_sel_e rsel;
		logic do_write;
		logic [7:0] rd;
		logic [5:0] ratio;
		state_next = state_reg;
		wsel = decode(state_reg.aw_addr);
		rsel = decode(axi_req.araddr);
		do_write = state_reg.aw_hold & state_reg.w_hold;
		rd = 8'h00;
		ratio = 6'h00;

		// hardware-set flags first so a same-cycle clear cannot drop an event
		state_next.irq_status = state_reg.irq_status | events;
		if (crc_fail)
			state_next.crc_ctrl[`CRC_FLAG_BIT] = 1'b1;

		// address and data may arrive in either order; each is held until both are in
		if (axi_req.awvalid && !state_reg.aw_hold && !state_reg.bvalid)
		begin
			state_next.aw_hold = 1'b1;
			state_next.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && !state_reg.w_hold && !state_reg.bvalid)
		begin
			state_next.w_hold = 1'b1;
			state_next.w_data = axi_req.wdata[7:0];
			state_next.w_lane0 = axi_req.wstrb[0];
		end

		if (do_write)
		begin
			state_next.aw_hold = 1'b0;
			state_next.w_hold = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			if (state_reg.w_lane0)
			begin
				case (wsel)
					SEL_SRC: state_next.src_sel = state_reg.w_data & `SRC_SEL_WMASK;
					SEL_PIN: state_next.pin_cfg = (state_reg.w_data & `PIN_CFG_WMASK)
						| (state_reg.pin_cfg & ~`PIN_CFG_WMASK);
					SEL_BUF: state_next.buf_ctrl = state_reg.w_data & `BUF_CTRL_WMASK;
					SEL_CLR: state_next.irq_status = (state_reg.irq_status
						& ~state_reg.w_data[`IRQ_W-1:0]) | events;
					SEL_EN: state_next.irq_enable = state_reg.w_data[`IRQ_W-1:0];
					SEL_CRC:
					begin
						state_next.crc_ctrl[`CRC_EN_BIT] = state_reg.w_data[`CRC_EN_BIT];
						if (state_reg.w_data[`CRC_FLAG_BIT] && !crc_fail)
							state_next.crc_ctrl[`CRC_FLAG_BIT] = 1'b0;
					end
					default: ;
				endcase
			end
		end
		if (state_reg.bvalid && axi_req.bready)
			state_next.bvalid = 1'b0;

		if (state_reg.rvalid && axi_req.rready)
			state_next.rvalid = 1'b0;
		if (axi_req.arvalid && !state_reg.rvalid)
		begin
			case (rsel)
				SEL_SRC: rd = state_reg.src_sel;
				SEL_PIN: rd = state_reg.pin_cfg;
				SEL_BUF: rd = state_reg.buf_ctrl;
				SEL_STAT: rd = 8'(state_reg.irq_status);
				SEL_EN: rd = 8'(state_reg.irq_enable);
				SEL_CRC: rd = state_reg.crc_ctrl;
				default: rd = 8'h00; // clear register is write-only
			endcase
			state_next.rvalid = 1'b1;
			state_next.rdata = rd;
			state_next.rresp = (rsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end

		// latched only while the input is enabled, so a stale level cannot linger
		state_next.pin_cfg[`PIN_IN_STAT_BIT] =
			state_reg.pin_cfg[`PIN_IN_EN_BIT] & error_input_pin;

		state_next.err_oe = state_reg.pin_cfg[`PIN_OUT_EN_BIT];
		state_next.err_out = state_reg.pin_cfg[`PIN_OUT_EN_BIT] & err_level;

		ratio = ratio_of(state_reg.buf_ctrl[`BUF_RATIO_HI:`BUF_RATIO_LO]);
		state_next.cm.powerdown = state_reg.buf_ctrl[`BUF_PD_BIT];
		state_next.cm.source_select = state_reg.buf_ctrl[`BUF_SRC_BIT];
		state_next.cm.ratio_code = state_reg.buf_ctrl[`BUF_RATIO_HI:`BUF_RATIO_LO];
		state_next.cm.ratio_twentieths = ratio[4:0];
		state_next.cm.ratio_reserved = ratio[5];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= '0;
			state_reg.src_sel <= `SRC_SEL_RST;
			state_reg.pin_cfg <= `PIN_CFG_RST;
			state_reg.buf_ctrl <= `BUF_CTRL_RST;
			state_reg.crc_ctrl <= `CRC_CTRL_RST;
			state_reg.cm.ratio_twentieths <= `RATIO_MID;
		end
		else
			state_reg <= state_next;
	end

	always_comb
	begin
		axi_rsp.awready = !state_reg.aw_hold && !state_reg.bvalid;
		axi_rsp.wready = !state_reg.w_hold && !state_reg.bvalid;
		axi_rsp.bvalid = state_reg.bvalid;
		axi_rsp.bresp = state_reg.bresp;
		axi_rsp.arready = !state_reg.rvalid;
		axi_rsp.rvalid = state_reg.rvalid;
		axi_rsp.rdata = {24'h000000, state_reg.rdata};
		axi_rsp.rresp = state_reg.rresp;
	end

	assign error_output_pin = state_reg.err_out;
	assign error_output_pin_oe = state_reg.err_oe;
	assign serial_crc_append = state_reg.crc_ctrl[`CRC_EN_BIT];
	assign common_mode = state_reg.cm;
	assign irq = |(state_reg.irq_status & state_reg.irq_enable);

endmodule : error_pin_and_vcm_control

// ==== hw/error_pin_regs.svh ====
`ifndef ERROR_PIN_REGS_SVH
`define ERROR_PIN_REGS_SVH

`define ADDR_W 12
// register indices; byte address is four times the index
`define IDX_SRC_SEL 10'h022
`define IDX_PIN_CFG 10'h023
`define IDX_BUF_CTRL 10'h024
`define IDX_IRQ_STATUS 10'h030
`define IDX_IRQ_CLEAR 10'h031
`define IDX_IRQ_ENABLE 10'h032
`define IDX_CRC_CTRL 10'h033

`define SRC_SEL_RST 8'h00
`define PIN_CFG_RST 8'h00
`define BUF_CTRL_RST 8'h00
`define CRC_CTRL_RST 8'h00
`define SRC_SEL_WMASK 8'h38
`define PIN_CFG_WMASK 8'h03
`define BUF_CTRL_WMASK 8'h7f
`define CRC_CTRL_WMASK 8'h01

`define SRC_OVR_BIT 5
`define SRC_INT_BIT 4
`define SRC_SPI_BIT 3
`define PIN_IN_STAT_BIT 2
`define PIN_IN_EN_BIT 1
`define PIN_OUT_EN_BIT 0
`define BUF_PD_BIT 6
`define BUF_RATIO_HI 5
`define BUF_RATIO_LO 1
`define BUF_SRC_BIT 0
`define CRC_EN_BIT 0
`define CRC_FLAG_BIT 1

`define IRQ_W 5
`define IRQ_OVR 0
`define IRQ_INT 1
`define IRQ_SPI 2
`define IRQ_EXT 3
`define IRQ_CRC 4

`define RATIO_MID 5'h0a
`define RATIO_CODE_RSVD 5'h01
`define RATIO_HI_FIRST 5'h02
`define RATIO_HI_LAST 5'h0a
`define RATIO_LO_LAST 5'h13
`define RATIO_MID_FIRST 5'h1d
`define RATIO_HI_BASE 5'h15
`define RATIO_LO_BASE 5'h14

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hw/error_pin_pkg.sv ====
`include "error_pin_regs.svh"

package error_pin_pkg;
	typedef enum {SEL_NONE, SEL_SRC, SEL_PIN, SEL_BUF, SEL_STAT, SEL_CLR, SEL_EN, SEL_CRC} reg_sel_e;

	typedef struct packed {
		logic awvalid;
		logic [`ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [`ADDR_W-1:0] araddr;
		logic rready;
	} axi_lite_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axi_lite_rsp_s;

	typedef struct packed {
		logic overrange;
		logic digital_overflow;
		logic map_crc;
		logic rate_converter;
		logic fuse_crc;
		logic data_clock_count;
		logic serial_read;
		logic serial_write;
		logic serial_crc_fail;
		logic serial_clock_count;
	} fault_in_s;

	typedef struct packed {
		logic powerdown;
		logic source_select;
		logic [4:0] ratio_code;
		logic [4:0] ratio_twentieths;
		logic ratio_reserved;
	} common_mode_s;

	typedef struct packed {
		logic aw_hold;
		logic [`ADDR_W-1:0] aw_addr;
		logic w_hold;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [7:0] src_sel;
		logic [7:0] pin_cfg;
		logic [7:0] buf_ctrl;
		logic [7:0] crc_ctrl;
		logic [`IRQ_W-1:0] irq_status;
		logic [`IRQ_W-1:0] irq_enable;
		logic err_out;
		logic err_oe;
		common_mode_s cm;
	} state_s;
endpackage : error_pin_pkg

// ==== tb/error_pin_checker.sv ====
`timescale 1ns/100ps
module error_pin_checker
	import error_pin_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire axi_lite_req_s axi_req,
	input wire axi_lite_rsp_s axi_rsp,
	input wire fault_in_s faults,
	input wire logic error_input_pin,
	input wire logic error_output_pin,
	input wire logic error_output_pin_oe,
	input wire logic serial_crc_append,
	input wire common_mode_s common_mode,
	input wire logic irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_oe;
		error_output_pin |-> error_output_pin_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("pin high undriven");
	property p_hi;
		common_mode.ratio_code inside {[2:10]} |->
			common_mode.ratio_twentieths == 5'h15 - common_mode.ratio_code;
	endproperty
	a_hi: assert property (p_hi) else $error("upper ratio");
	property p_lo;
		common_mode.ratio_code inside {[11:19]} |->
			common_mode.ratio_twentieths == 5'h14 - common_mode.ratio_code;
	endproperty
	a_lo: assert property (p_lo) else $error("lower ratio");
	property p_mid;
		common_mode.ratio_code == 5'h00 || common_mode.ratio_code >= 5'h1d |->
			common_mode.ratio_twentieths == 5'h0a && !common_mode.ratio_reserved;
	endproperty
	a_mid: assert property (p_mid) else $error("mid ratio");
	property p_rsv;
		common_mode.ratio_code == 5'h01 |-> common_mode.ratio_reserved;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code");
	property p_rd;
		axi_rsp.rvalid |-> axi_rsp.rdata[31:7] == 25'h0;
	endproperty
	a_rd: assert property (p_rd) else $error("upper read bits");
	property p_quiet;
		faults == '0 && !error_input_pin |=> !error_output_pin;
	endproperty
	a_quiet: assert property (p_quiet) else $error("pin without source");
	property p_rise;
		$rose(error_output_pin) |-> $past(faults) != '0 || $past(error_input_pin);
	endproperty
	a_rise: assert property (p_rise) else $error("rise without cause");
endmodule : error_pin_checker

bind error_pin_and_vcm_control error_pin_checker error_pin_checker_inst (.aclk(aclk),
	.aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .faults(faults),
	.error_input_pin(error_input_pin), .error_output_pin(error_output_pin),
	.error_output_pin_oe(error_output_pin_oe), .serial_crc_append(serial_crc_append),
	.common_mode(common_mode), .irq(irq));

// ==== tb/error_chain_source.sv ====
`timescale 1ns/100ps
module error_chain_source
(
	input wire logic aclk,
	input wire logic raise,
	output logic error_input_pin = 1'b0
);
	// upstream fault is a plain level, launched on the clock
	always_ff @(posedge aclk)
		error_input_pin <= raise;
endmodule : error_chain_source

// ==== tb/test_error_pin_and_vcm_control.sv ====
`timescale 1ns/100ps
`include "error_pin_regs.svh"
module test_error_pin_and_vcm_control
	import error_pin_pkg::*;
;
	localparam logic [11:0] ad_src = 12'h088, ad_pin = 12'h08c, ad_buf = 12'h090;
	localparam logic [11:0] ad_stat = 12'h0c0, ad_clr = 12'h0c4, ad_en = 12'h0c8, ad_crc = 12'h0cc;
	localparam logic [1:0] ok = `RESP_OKAY, se = `RESP_SLVERR;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic raise = 1'b0;
	axi_lite_req_s req = '{wstrb: 4'hf, bready: 1'b1, rready: 1'b1, default: '0};
	axi_lite_rsp_s rsp;
	fault_in_s flt = '0;
	common_mode_s cm;
	logic chain, pin, pin_oe, crc_app, irq;
	int num_errors = 0;
	int checked = 0;
	error_pin_and_vcm_control error_pin_and_vcm_control_inst (.aclk(aclk), .aresetn(aresetn),
		.axi_req(req), .axi_rsp(rsp), .faults(flt), .error_input_pin(chain),
		.error_output_pin(pin), .error_output_pin_oe(pin_oe), .serial_crc_append(crc_app),
		.common_mode(cm), .irq(irq));
	error_chain_source error_chain_source_inst (.aclk(aclk), .raise(raise), .error_input_pin(chain));
	initial forever #10 aclk = ~aclk;
	task automatic conclude;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic w3;
		repeat (3) @(posedge aclk);
	endtask : w3
	// bready and rready stay high, so no answer is ever left waiting
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
		int n;
		logic aw_ok;
		logic w_ok;
		logic b_seen;
		logic [1:0] resp;
		n = 0;
		b_seen = 1'b0;
		resp = 2'h0;
		req.awaddr <= a;
		req.wdata <= {24'h0, d};
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		do
		begin
			// slave outputs taken mid-cycle, where they have settled before the edge
			@(negedge aclk);
			aw_ok = rsp.awready;
			w_ok = rsp.wready;
			b_seen = rsp.bvalid;
			resp = rsp.bresp;
			@(posedge aclk);
			n++;
			if (aw_ok) req.awvalid <= 1'b0;
			if (w_ok) req.wvalid <= 1'b0;
		end
		while (b_seen !== 1'b1 && n < 50);
		chk("bvalid", b_seen, 1'b1);
		chk("bresp", resp, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		int n;
		logic ar_ok;
		logic r_seen;
		logic [31:0] data;
		logic [1:0] resp;
		n = 0;
		r_seen = 1'b0;
		data = 32'h0;
		resp = 2'h0;
		req.araddr <= a;
		req.arvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			ar_ok = rsp.arready;
			r_seen = rsp.rvalid;
			data = rsp.rdata;
			resp = rsp.rresp;
			@(posedge aclk);
			n++;
			if (ar_ok) req.arvalid <= 1'b0;
		end
		while (r_seen !== 1'b1 && n < 50);
		chk("rvalid", r_seen, 1'b1);
		chk("rdata", data, {24'h0, e});
		chk("rresp", resp, er);
	endtask : rd
	function automatic logic exp_pin(input int k, input int i, input int c);
		if (i == 9) return k == 5;
		if (i >= 4) return k == 4;
		return k == 3 && (i != 1 || c == 1);
	endfunction : exp_pin
	function automatic logic [4:0] tw(input int c);
		if (c >= 2 && c <= 10) return 5'(21 - c);
		if (c >= 11 && c <= 19) return 5'(20 - c);
		return 5'h0a;
	endfunction : tw
	task automatic t_sources;
		rd(ad_src, 8'h00, ok);
		rd(ad_pin, 8'h00, ok);
		wr(ad_src, 8'hff, ok);
		rd(ad_src, 8'h38, ok);
		wr(ad_pin, 8'h01, ok);
		for (int c = 0; c < 2; c++)
		begin
			wr(ad_crc, 8'(c), ok);
			chk("crc", crc_app, c[0]);
			for (int k = 3; k < 6; k++)
			begin
				wr(ad_src, 8'h01 << k, ok);
				for (int i = 0; i < 10; i++)
				begin
					flt <= fault_in_s'(10'h001 << i);
					w3();
					chk("pin", pin, exp_pin(k, i, c));
					flt <= '0;
					w3();
				end
			end
		end
	endtask : t_sources
	task automatic t_chain;
		wr(ad_src, 8'h00, ok);
		wr(ad_pin, 8'h03, ok);
		raise <= 1'b1;
		w3();
		chk("chain", pin, 1'b1);
		chk("oe on", pin_oe, 1'b1);
		wr(ad_pin, 8'hf8, ok);
		rd(ad_pin, 8'h00, ok);
		wr(ad_pin, 8'h03, ok);
		w3();
		rd(ad_pin, 8'h07, ok);
		wr(ad_pin, 8'h01, ok);
		w3();
		chk("chain off", pin, 1'b0);
		rd(ad_pin, 8'h01, ok);
		raise <= 1'b0;
		wr(ad_pin, 8'h00, ok);
		w3();
		chk("oe", pin_oe, 1'b0);
	endtask : t_chain
	task automatic t_buf;
		rd(ad_buf, 8'h00, ok);
		for (int c = 0; c < 32; c++)
		begin
			wr(ad_buf, {1'b1, c[0], c[4:0], c[1]}, ok);
			w3();
			chk("pd", cm.powerdown, c[0]);
			chk("sel", cm.source_select, c[1]);
			chk("code", cm.ratio_code, c[4:0]);
			chk("tw", cm.ratio_twentieths, tw(c));
			chk("rsv", cm.ratio_reserved, c == 1 || (c >= 20 && c <= 28));
		end
		rd(ad_buf, 8'h7f, ok);
	endtask : t_buf
	task automatic t_irq;
		wr(ad_clr, 8'h1f, ok);
		wr(ad_en, 8'h01, ok);
		flt <= fault_in_s'(10'h200);
		w3();
		flt <= '0;
		w3();
		chk("irq", irq, 1'b1);
		rd(ad_stat, 8'h01, ok);
		wr(ad_en, 8'h00, ok);
		w3();
		chk("masked", irq, 1'b0);
		wr(ad_en, 8'h01, ok);
		wr(ad_clr, 8'h01, ok);
		w3();
		chk("cleared", irq, 1'b0);
		rd(ad_clr, 8'h00, ok);
		wr(12'h400, 8'h55, se);
		rd(12'h400, 8'h00, se);
		wr(12'h089, 8'h01, se);
		rd(ad_crc, 8'h03, ok);
		wr(ad_crc, 8'h02, ok);
		chk("crc off", crc_app, 1'b0);
		rd(ad_crc, 8'h00, ok);
	endtask : t_irq
	initial
	begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		conclude();
	end
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_sources();
		t_chain();
		t_buf();
		t_irq();
		conclude();
	end
endmodule : test_error_pin_and_vcm_control
